// File: src/sfe_top.sv
// Erase command decoder, self-timed cycle sequencer and deep power-down control.
`default_nettype none
`include "sfe_map.svh"

module sfe_top #(
    parameter int unsigned ADDR_W            = 24,
    parameter int unsigned ERASE_CYCLES      = `SFE_ERASE_CYCLES,
    parameter int unsigned FULL_ERASE_CYCLES = `SFE_FULL_ERASE_CYCLES
) (
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              sclk_i,
    input  wire logic              cs_n_i,
    input  wire logic              si_i,
    input  wire logic [4:0]        protect_bits_i,
    input  wire logic              protect_complement_i,
    input  wire logic              region_protected_i,
    output logic                   so_o,
    output logic                   so_oe_o,
    output logic                   write_in_progress_o,
    output logic                   write_enable_latch_o,
    output logic                   standby_o,
    output logic                   deep_sleep_o,
    output logic                   erase_start_o,
    output sfe_pkg::sfe_kind_t     erase_kind_o,
    output logic [ADDR_W-1:0]      erase_base_o
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------

    // Clears the in-region offset so any address inside the region is valid.
    function automatic logic [ADDR_W-1:0] sfe_align(input logic [ADDR_W-1:0] a,
                                                    input sfe_pkg::sfe_kind_t k);
        logic [ADDR_W-1:0] m;
        m = '1;
        case (k)
            sfe_pkg::SFE_KIND_SECTOR: m = m << `SFE_SECTOR_LOW_BITS;
            sfe_pkg::SFE_KIND_BLK32:  m = m << `SFE_BLK32_LOW_BITS;
            sfe_pkg::SFE_KIND_BLK64:  m = m << `SFE_BLK64_LOW_BITS;
            default:                  m = '0;
        endcase
        return a & m;
    endfunction

    // Chip erase is allowed only when the low three protect bits are all clear without complement or all set with it.
    function automatic logic sfe_chip_allowed(input logic [2:0] low, input logic cpl);
        return ((low == `SFE_PROTECT_LOW_ZERO) && !cpl) ||
               ((low == `SFE_PROTECT_LOW_ONES) && cpl);
    endfunction

    // ------------------------------------------------------------------------
    // Link domain
    // ------------------------------------------------------------------------
    logic [7:0] link_byte;
    logic       link_tgl;
    logic       link_part;

    sfe_link u_link (
        .sclk_i     (sclk_i),
        .rst_n_i    (rst_n_i),
        .cs_n_i     (cs_n_i),
        .si_i       (si_i),
        .byte_o     (link_byte),
        .byte_tgl_o (link_tgl),
        .partial_o  (link_part)
    );

    // ------------------------------------------------------------------------
    // Crossing into the core clock
    // ------------------------------------------------------------------------
    logic cs_s1_q;
    logic cs_s2_q;
    logic cs_s3_q;
    logic tgl_s1_q;
    logic tgl_s2_q;
    logic tgl_s3_q;
    logic part_s1_q;
    logic part_s2_q;

    // Select starts high so a reset never looks like a frame end.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cs_s1_q   <= 1'b1;
            cs_s2_q   <= 1'b1;
            cs_s3_q   <= 1'b1;
            tgl_s1_q  <= 1'b0;
            tgl_s2_q  <= 1'b0;
            tgl_s3_q  <= 1'b0;
            part_s1_q <= 1'b0;
            part_s2_q <= 1'b0;
        end else begin
            cs_s1_q   <= cs_n_i;
            cs_s2_q   <= cs_s1_q;
            cs_s3_q   <= cs_s2_q;
            tgl_s1_q  <= link_tgl;
            tgl_s2_q  <= tgl_s1_q;
            tgl_s3_q  <= tgl_s2_q;
            part_s1_q <= link_part;
            part_s2_q <= part_s1_q;
        end
    end

    logic byte_evt;
    logic cs_fall;
    logic cs_rise;

    // The held byte is stable for eight serial clocks after its toggle, far longer than the sync delay.
    assign byte_evt = tgl_s2_q ^ tgl_s3_q;
    assign cs_fall  = !cs_s2_q && cs_s3_q;
    assign cs_rise  = cs_s2_q && !cs_s3_q;

    // ------------------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------------------
    sfe_pkg::sfe_state_t state_q;
    sfe_pkg::sfe_state_t state_d;
    sfe_pkg::sfe_kind_t  kind_q;
    sfe_pkg::sfe_kind_t  kind_d;
    logic [2:0]          bcnt_q;
    logic [2:0]          bcnt_d;
    logic [7:0]          op_q;
    logic [7:0]          op_d;
    logic [ADDR_W-1:0]   addr_q;
    logic [ADDR_W-1:0]   addr_d;
    logic [ADDR_W-1:0]   base_q;
    logic [ADDR_W-1:0]   base_d;
    logic [31:0]         timer_q;
    logic [31:0]         timer_d;
    logic                wen_q;
    logic                wen_d;
    logic                rb_en_q;
    logic                rb_en_d;
    logic                start_q;
    logic                start_d;
    logic                bsy_q;
    logic                bsy_d;
    logic                so_q;
    logic                so_d;
    logic                so_oe_q;
    logic                so_oe_d;
    logic                standby_q;
    logic                standby_d;
    logic                sleep_q;
    logic                sleep_d;

    logic op_only;
    logic addr_ok;
    logic timer_done;

    // A frame counts only when it closed on the exact byte boundary its opcode needs.
    assign op_only    = cs_rise && (bcnt_q == `SFE_BYTES_OPCODE_ONLY) && !part_s2_q;
    assign addr_ok    = cs_rise && (bcnt_q == `SFE_BYTES_WITH_ADDR) && !part_s2_q;
    assign timer_done = (timer_q == 32'h0000_0000);

    // Next-state computation for the whole sequencer.
    always_comb begin
        state_d = state_q;
        kind_d  = kind_q;
        bcnt_d  = bcnt_q;
        op_d    = op_q;
        addr_d  = addr_q;
        base_d  = base_q;
        timer_d = timer_q;
        wen_d   = wen_q;
        rb_en_d = rb_en_q;
        start_d = 1'b0;

        // Byte assembly: opcode first, then address bytes most significant first.
        if (cs_fall) begin
            bcnt_d = 3'h0;
        end else if (byte_evt) begin
            if (bcnt_q == 3'h0) begin
                op_d = link_byte;
            end else if (bcnt_q < `SFE_BYTES_WITH_ADDR) begin
                addr_d = ADDR_W'({addr_q, link_byte});
            end
            if (bcnt_q != `SFE_BYTES_SATURATE) begin
                bcnt_d = 3'(bcnt_q + 3'h1);
            end
        end

        if (!timer_done) begin
            timer_d = 32'(timer_q - 32'h1);
        end

        // Ready/busy output control is honoured in every state but sleep entry and deep sleep.
        if (op_only && (state_q != sfe_pkg::SFE_SLEEP) && (state_q != sfe_pkg::SFE_SLEEP_ENTRY)) begin
            if (op_q == `SFE_OP_RB_OUT_ENABLE) begin
                rb_en_d = 1'b1;
            end else if (op_q == `SFE_OP_RB_OUT_DISABLE) begin
                rb_en_d = 1'b0;
            end
        end

        case (state_q)
            sfe_pkg::SFE_POWER_ON: begin
                if (timer_done) begin
                    state_d = sfe_pkg::SFE_STANDBY;
                end
            end
            sfe_pkg::SFE_STANDBY: begin
                if (op_only && (op_q == `SFE_OP_WRITE_ENABLE)) begin
                    wen_d = 1'b1;
                end else if (op_only && (op_q == `SFE_OP_DEEP_SLEEP)) begin
                    timer_d = 32'(`SFE_SLEEP_ENTRY_CYCLES - 1);
                    state_d = sfe_pkg::SFE_SLEEP_ENTRY;
                end else if (op_only && wen_q &&
                             ((op_q == `SFE_OP_CHIP_ERASE_A) || (op_q == `SFE_OP_CHIP_ERASE_B))) begin
                    // Chip erase needs no region verdict, only the protect pattern.
                    if (sfe_chip_allowed(protect_bits_i[2:0], protect_complement_i)) begin
                        kind_d  = sfe_pkg::SFE_KIND_CHIP;
                        base_d  = '0;
                        wen_d   = 1'b0;
                        start_d = 1'b1;
                        timer_d = 32'(FULL_ERASE_CYCLES - 1);
                        state_d = sfe_pkg::SFE_ERASE;
                    end
                end else if (addr_ok && wen_q) begin
                    if (op_q == `SFE_OP_SECTOR_ERASE) begin
                        kind_d  = sfe_pkg::SFE_KIND_SECTOR;
                        base_d  = sfe_align(addr_q, sfe_pkg::SFE_KIND_SECTOR);
                        state_d = sfe_pkg::SFE_CHECK;
                    end else if (op_q == `SFE_OP_BLK32_ERASE) begin
                        kind_d  = sfe_pkg::SFE_KIND_BLK32;
                        base_d  = sfe_align(addr_q, sfe_pkg::SFE_KIND_BLK32);
                        state_d = sfe_pkg::SFE_CHECK;
                    end else if (op_q == `SFE_OP_BLK64_ERASE) begin
                        kind_d  = sfe_pkg::SFE_KIND_BLK64;
                        base_d  = sfe_align(addr_q, sfe_pkg::SFE_KIND_BLK64);
                        state_d = sfe_pkg::SFE_CHECK;
                    end
                end
            end
            sfe_pkg::SFE_CHECK: begin
                // The outside protect map judges the region base in the same cycle it is posted.
                if (region_protected_i) begin
                    state_d = sfe_pkg::SFE_STANDBY;
                end else begin
                    wen_d   = 1'b0;
                    start_d = 1'b1;
                    timer_d = 32'(ERASE_CYCLES - 1);
                    state_d = sfe_pkg::SFE_ERASE;
                end
            end
            sfe_pkg::SFE_ERASE: begin
                // Deep sleep and further erases are dropped here, the cycle runs on.
                if (timer_done) begin
                    state_d = sfe_pkg::SFE_STANDBY;
                end
            end
            sfe_pkg::SFE_SLEEP_ENTRY: begin
                if (timer_done) begin
                    state_d = sfe_pkg::SFE_SLEEP;
                end
            end
            sfe_pkg::SFE_SLEEP: begin
                // Only the wake opcode, alone or followed by whole dummy bytes, is heard.
                if (cs_rise && !part_s2_q && (bcnt_q != 3'h0) &&
                    (op_q == `SFE_OP_WAKE_AND_ID)) begin
                    timer_d = 32'(`SFE_WAKE_CYCLES - 1);
                    state_d = sfe_pkg::SFE_WAKE;
                end
            end
            sfe_pkg::SFE_WAKE: begin
                if (timer_done) begin
                    state_d = sfe_pkg::SFE_STANDBY;
                end
            end
            default: begin
                state_d = sfe_pkg::SFE_STANDBY;
            end
        endcase

        // Outputs are computed from the next state so each output is a plain flop.
        bsy_d     = (state_d == sfe_pkg::SFE_ERASE);
        standby_d = (state_d == sfe_pkg::SFE_STANDBY);
        sleep_d   = (state_d == sfe_pkg::SFE_SLEEP);
        so_d      = standby_d;
        so_oe_d   = rb_en_d && cs_s2_q;
    end

    // Registers of the sequencer; power-on always lands in standby later.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q   <= sfe_pkg::SFE_POWER_ON;
            kind_q    <= sfe_pkg::SFE_KIND_SECTOR;
            bcnt_q    <= 3'h0;
            op_q      <= 8'h00;
            addr_q    <= '0;
            base_q    <= '0;
            timer_q   <= 32'(`SFE_POWER_ON_CYCLES - 1);
            wen_q     <= 1'b0;
            rb_en_q   <= 1'b0;
            start_q   <= 1'b0;
            bsy_q     <= 1'b0;
            so_q      <= 1'b0;
            so_oe_q   <= 1'b0;
            standby_q <= 1'b0;
            sleep_q   <= 1'b0;
        end else begin
            state_q   <= state_d;
            kind_q    <= kind_d;
            bcnt_q    <= bcnt_d;
            op_q      <= op_d;
            addr_q    <= addr_d;
            base_q    <= base_d;
            timer_q   <= timer_d;
            wen_q     <= wen_d;
            rb_en_q   <= rb_en_d;
            start_q   <= start_d;
            bsy_q     <= bsy_d;
            so_q      <= so_d;
            so_oe_q   <= so_oe_d;
            standby_q <= standby_d;
            sleep_q   <= sleep_d;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign so_o                 = so_q;
    assign so_oe_o              = so_oe_q;
    assign write_in_progress_o  = bsy_q;
    assign write_enable_latch_o = wen_q;
    assign standby_o            = standby_q;
    assign deep_sleep_o         = sleep_q;
    assign erase_start_o        = start_q;
    assign erase_kind_o         = kind_q;
    assign erase_base_o         = base_q;

endmodule

`default_nettype wire

// File: src/sfe_map.svh
// Opcodes, address geometry and timing constants of the erase and power-down sequencer.
`ifndef SFE_MAP_SVH
`define SFE_MAP_SVH

// ----------------------------------------------------------------------------
// Command opcodes
// ----------------------------------------------------------------------------
`define SFE_OP_WRITE_ENABLE   8'h06
`define SFE_OP_SECTOR_ERASE   8'h20
`define SFE_OP_BLK32_ERASE    8'h52
`define SFE_OP_BLK64_ERASE    8'hD8
`define SFE_OP_CHIP_ERASE_A   8'h60
`define SFE_OP_CHIP_ERASE_B   8'hC7
`define SFE_OP_RB_OUT_ENABLE  8'h70
`define SFE_OP_RB_OUT_DISABLE 8'h80
`define SFE_OP_DEEP_SLEEP     8'hB9
`define SFE_OP_WAKE_AND_ID    8'hAB

// ----------------------------------------------------------------------------
// Frame geometry
// ----------------------------------------------------------------------------
`define SFE_BYTES_OPCODE_ONLY 3'h1
`define SFE_BYTES_WITH_ADDR   3'h4
`define SFE_BYTES_SATURATE    3'h5
`define SFE_SECTOR_LOW_BITS   12
`define SFE_BLK32_LOW_BITS    15
`define SFE_BLK64_LOW_BITS    16
`define SFE_PROTECT_LOW_ZERO  3'h0
`define SFE_PROTECT_LOW_ONES  3'h7

// ----------------------------------------------------------------------------
// Timing, core clock 4 ns
// ----------------------------------------------------------------------------
`define SFE_CLK_PERIOD_PS          4000
`define SFE_ERASE_CYCLE_TIME_US    50
`define SFE_FULL_ERASE_TIME_US     400
`define SFE_SLEEP_ENTRY_DELAY_NS   3000
`define SFE_WAKE_DELAY_NS          3000
`define SFE_POWER_ON_TIME_NS       1000
`define SFE_ERASE_CYCLES  ((`SFE_ERASE_CYCLE_TIME_US * 1000000) / `SFE_CLK_PERIOD_PS)
`define SFE_FULL_ERASE_CYCLES ((`SFE_FULL_ERASE_TIME_US * 1000000) / `SFE_CLK_PERIOD_PS)
`define SFE_SLEEP_ENTRY_CYCLES ((`SFE_SLEEP_ENTRY_DELAY_NS * 1000 + `SFE_CLK_PERIOD_PS - 1) / `SFE_CLK_PERIOD_PS)
`define SFE_WAKE_CYCLES   ((`SFE_WAKE_DELAY_NS * 1000 + `SFE_CLK_PERIOD_PS - 1) / `SFE_CLK_PERIOD_PS)
`define SFE_POWER_ON_CYCLES ((`SFE_POWER_ON_TIME_NS * 1000 + `SFE_CLK_PERIOD_PS - 1) / `SFE_CLK_PERIOD_PS)

`endif

// File: src/sfe_pkg.sv
// Types shared by the erase and power-down sequencer.
`default_nettype none

package sfe_pkg;

    // ------------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        SFE_POWER_ON    = 3'b000,
        SFE_STANDBY     = 3'b001,
        SFE_CHECK       = 3'b010,
        SFE_ERASE       = 3'b011,
        SFE_SLEEP_ENTRY = 3'b100,
        SFE_SLEEP       = 3'b101,
        SFE_WAKE        = 3'b110
    } sfe_state_t;

    // ------------------------------------------------------------------------
    // Erase region kinds
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        SFE_KIND_SECTOR = 2'b00,
        SFE_KIND_BLK32  = 2'b01,
        SFE_KIND_BLK64  = 2'b10,
        SFE_KIND_CHIP   = 2'b11
    } sfe_kind_t;

endpackage

`default_nettype wire

// File: src/sfe_link.sv
// Serial shifter on the link clock: gathers bytes and hands them to the core domain.
`default_nettype none

module sfe_link (
    input  wire logic       sclk_i,
    input  wire logic       rst_n_i,
    input  wire logic       cs_n_i,
    input  wire logic       si_i,
    output logic [7:0]      byte_o,
    output logic            byte_tgl_o,
    output logic            partial_o
);

    // ------------------------------------------------------------------------
    // Frame and handover state
    // ------------------------------------------------------------------------
    logic       frame_rst_n;
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic [6:0] sh_q;
    logic [6:0] sh_d;
    logic [7:0] byte_q;
    logic [7:0] byte_d;
    logic       tgl_q;
    logic       tgl_d;
    logic       part_q;
    logic       part_d;

    // The bit counter restarts with every frame; the clock may stop between frames.
    assign frame_rst_n = rst_n_i & ~cs_n_i;

    // Bits arrive most significant first on each rising serial clock edge.
    always_comb begin
        cnt_d  = 3'(cnt_q + 3'h1);
        sh_d   = {sh_q[5:0], si_i};
        byte_d = byte_q;
        tgl_d  = tgl_q;
        if (cnt_q == 3'h7) begin
            byte_d = {sh_q, si_i};
            tgl_d  = ~tgl_q;
        end
        part_d = (cnt_d != 3'h0);
    end

    // Counter and shifter clear while deselected.
    always_ff @(posedge sclk_i or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            cnt_q <= 3'h0;
            sh_q  <= 7'h00;
        end else begin
            cnt_q <= cnt_d;
            sh_q  <= sh_d;
        end
    end

    // Handover words survive the end of a frame so the core can read them after it.
    always_ff @(posedge sclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            byte_q <= 8'h00;
            tgl_q  <= 1'b0;
            part_q <= 1'b0;
        end else begin
            byte_q <= byte_d;
            tgl_q  <= tgl_d;
            part_q <= part_d;
        end
    end

    assign byte_o     = byte_q;
    assign byte_tgl_o = tgl_q;
    assign partial_o  = part_q;

endmodule

`default_nettype wire

// File: tb/sfe_top_assertions.sv
// Port-level checks of the erase and power-down sequencer.
`default_nettype none

module sfe_top_assertions #(
    parameter int unsigned ADDR_W = 24
) (
    input wire logic               clk_i,
    input wire logic               rst_n_i,
    input wire logic               cs_n_i,
    input wire logic [4:0]         protect_bits_i,
    input wire logic               protect_complement_i,
    input wire logic               region_protected_i,
    input wire logic               so_o,
    input wire logic               so_oe_o,
    input wire logic               write_in_progress_o,
    input wire logic               write_enable_latch_o,
    input wire logic               standby_o,
    input wire logic               deep_sleep_o,
    input wire logic               erase_start_o,
    input wire sfe_pkg::sfe_kind_t erase_kind_o,
    input wire logic [ADDR_W-1:0]  erase_base_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // Properties, all in the core clock domain
    // ------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    start_busy_a: assert property (erase_start_o |-> write_in_progress_o && !write_enable_latch_o)
        else $error("erase start without busy or with latch set");
    busy_cause_a: assert property ($rose(write_in_progress_o) |-> erase_start_o)
        else $error("busy rose without erase start");
    start_latch_a: assert property (erase_start_o |-> $past(write_enable_latch_o))
        else $error("erase started without write enable");
    sleep_quiet_a: assert property (deep_sleep_o |-> !standby_o && !write_in_progress_o && !erase_start_o)
        else $error("activity in deep sleep");
    busy_pin_a: assert property (write_in_progress_o && $past(write_in_progress_o) |-> !so_o)
        else $error("ready shown while erasing");
    ready_pin_a: assert property (standby_o && $past(standby_o) |-> so_o)
        else $error("busy shown in standby");
    pin_drive_a: assert property ($rose(so_oe_o) |-> cs_n_i)
        else $error("status pin driven while selected");
    target_held_a: assert property (write_in_progress_o && !erase_start_o |-> $stable(erase_base_o) && $stable(erase_kind_o))
        else $error("erase target moved during cycle");
    sector_align_a: assert property (erase_start_o && erase_kind_o == sfe_pkg::SFE_KIND_SECTOR |-> erase_base_o[11:0] == 12'h000)
        else $error("sector base not aligned");
    chip_guard_a: assert property (erase_start_o && erase_kind_o == sfe_pkg::SFE_KIND_CHIP
        |-> protect_bits_i[2:0] == (protect_complement_i ? 3'h7 : 3'h0))
        else $error("chip erase under protection");
    region_guard_a: assert property (erase_start_o && erase_kind_o != sfe_pkg::SFE_KIND_CHIP |-> !$past(region_protected_i))
        else $error("protected region erased");
endmodule

bind sfe_top sfe_top_assertions #(.ADDR_W(ADDR_W)) u_sfe_top_assertions (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .cs_n_i(cs_n_i), .protect_bits_i(protect_bits_i), .protect_complement_i(protect_complement_i),
    .region_protected_i(region_protected_i), .so_o(so_o), .so_oe_o(so_oe_o), .write_in_progress_o(write_in_progress_o),
    .write_enable_latch_o(write_enable_latch_o), .standby_o(standby_o), .deep_sleep_o(deep_sleep_o),
    .erase_start_o(erase_start_o), .erase_kind_o(erase_kind_o), .erase_base_o(erase_base_o));

`default_nettype wire

// File: tb/sfe_host.sv
// Host controller model that frames commands on the serial link.
`default_nettype none

module sfe_host (
    output logic sclk_o,
    output logic cs_n_o,
    output logic si_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // Frame driver
    // ------------------------------------------------------------
    // Idle link: deselected, clock parked low.
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        si_o   = 1'b0;
    end

    // Shifts n bits out from d[39] down; the clock runs only inside the frame.
    task automatic send(input logic [39:0] d, input int n);
        #100;                       // Deselect gap long enough for the core to see it
        cs_n_o = 1'b0;              // Held low to the last bit
        for (int i = 0; i < n; i++) begin
            si_o = d[39-i];
            #62.5 sclk_o = 1'b1;
            #62.5 sclk_o = 1'b0;
        end
        #62.5 cs_n_o = 1'b1;        // Caller picks whole or broken bytes
        si_o = ~si_o;               // Released line must not look stable.
    endtask
endmodule

`default_nettype wire

// File: tb/test_sfe_top.sv
// Self-checking bench for the erase and power-down sequencer.
`default_nettype none
`include "sfe_map.svh"

module test_sfe_top;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int EC = 400;
    localparam int FC = 1000;
    logic clk_i = 1'b0, rst_n_i = 1'b0, cpl_q = 1'b0, rgn_q = 1'b0;
    logic so, oe, bsy, wen, stby, slp, st;
    logic [4:0] prot_q = 5'h00;
    logic [23:0] base, adr;
    logic [31:0] r;
    wire logic sclk_w, cs_n_w, si_w;
    sfe_pkg::sfe_kind_t kind;
    int num_errors = 0, n_tests = 0, seed = 32'hDE96;

    sfe_host u_host (.sclk_o(sclk_w), .cs_n_o(cs_n_w), .si_o(si_w));
    sfe_top #(.ERASE_CYCLES(EC), .FULL_ERASE_CYCLES(FC)) u_sfe_top (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .sclk_i(sclk_w), .cs_n_i(cs_n_w), .si_i(si_w), .protect_bits_i(prot_q), .protect_complement_i(cpl_q),
        .region_protected_i(rgn_q), .so_o(so), .so_oe_o(oe), .write_in_progress_o(bsy),
        .write_enable_latch_o(wen), .standby_o(stby), .deep_sleep_o(slp), .erase_start_o(st),
        .erase_kind_o(kind), .erase_base_o(base));

    // Core clock, 4 ns period.
    always #2 clk_i = ~clk_i;

    // ------------------------------------------------------------
    // Checking and waiting helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Bounded wait; a lapse is a mismatch and ends the run, since later steps would be meaningless.
    task automatic wt(input int sel, input int lim, output int n);
        logic c;
        for (n = 0; n < lim; n++) begin
            @(posedge clk_i);
            #1;
            c = (sel == 0) ? stby : (sel == 1) ? st : (sel == 2) ? slp : (sel == 3) ? !bsy : wen;
            if (c === 1'b1) break;
        end
        if (n == lim) begin
            chk("wait bound", 32'h0, 32'h1);
            summarize();
        end
    endtask

    task automatic setp(input logic [2:0] p, input logic c, input logic g);
        @(posedge clk_i);
        r = $random(seed);
        prot_q <= {r[1:0], p};
        cpl_q <= c;
        rgn_q <= g;
    endtask

    // A frame the device must drop: no erase may follow.
    task automatic nope(input logic [39:0] d, input int nb, input bit w);
        if (w) u_host.send({`SFE_OP_WRITE_ENABLE, 32'h0}, 8);
        u_host.send(d, nb);
        repeat (30) @(posedge clk_i);
        #1;
        chk("refused", {31'h0, bsy}, 32'h0);
    endtask

    // Model: the expected base is the random address with the region's low bits cleared.
    task automatic run_erase(input logic [7:0] op, input logic [1:0] k, input int lowb, input int cyc, input bit ds);
        int n;
        logic [23:0] eb[$];
        r = $random(seed);
        adr = r[23:0];
        eb.push_back((k == 2'h3) ? 24'h000000 : adr & ~((24'h000001 << lowb) - 24'h000001));
        u_host.send({`SFE_OP_WRITE_ENABLE, 32'h0}, 8);
        wt(4, 40, n);
        u_host.send({op, adr, 8'h00}, (k == 2'h3) ? 8 : 32);
        wt(1, 40, n);
        chk("kind", {30'h0, kind}, {30'h0, k});
        chk("base", {8'h00, base}, {8'h00, eb.pop_front()});
        if (ds) begin
            u_host.send({`SFE_OP_DEEP_SLEEP, 32'h0}, 8);
            wt(3, cyc, n);
            repeat (800) @(posedge clk_i);
            #1;
            chk("sleep while busy", {30'h0, slp, stby}, 32'h1);
        end else begin
            @(posedge clk_i);
            #1;
            chk("busy pin", {30'h0, so, oe}, 32'h1);
            repeat (cyc - 2) @(posedge clk_i);
            #1;
            chk("busy last", {31'h0, bsy}, 32'h1);
            @(posedge clk_i);
            #1;
            chk("busy done", {31'h0, bsy}, 32'h0);
        end
        wt(0, 10, n);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int n;
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        wt(0, 400, n);
        chk("power up", {30'h0, so, slp}, 32'h2);
        nope({`SFE_OP_SECTOR_ERASE, 32'h0}, 32, 1'b0);
        nope({`SFE_OP_SECTOR_ERASE, 32'h0}, 35, 1'b1);
        setp(3'h0, 1'b0, 1'b1);
        nope({`SFE_OP_BLK64_ERASE, 32'h0}, 32, 1'b1);
        setp(3'h1, 1'b0, 1'b0);
        nope({`SFE_OP_CHIP_ERASE_A, 32'h0}, 8, 1'b1);
        setp(3'h0, 1'b0, 1'b0);
        nope({`SFE_OP_CHIP_ERASE_B, 32'h0}, 9, 1'b1);
        u_host.send({`SFE_OP_RB_OUT_ENABLE, 32'h0}, 8);
        run_erase(`SFE_OP_SECTOR_ERASE, 2'h0, 12, EC, 1'b0);
        run_erase(`SFE_OP_BLK32_ERASE, 2'h1, 15, EC, 1'b0);
        run_erase(`SFE_OP_BLK64_ERASE, 2'h2, 16, EC, 1'b0);
        run_erase(`SFE_OP_CHIP_ERASE_A, 2'h3, 0, FC, 1'b0);
        setp(3'h7, 1'b1, 1'b0);
        run_erase(`SFE_OP_CHIP_ERASE_B, 2'h3, 0, FC, 1'b1);
        u_host.send({`SFE_OP_RB_OUT_DISABLE, 32'h0}, 8);
        repeat (20) @(posedge clk_i);
        #1;
        chk("pin released", {31'h0, oe}, 32'h0);
        u_host.send({`SFE_OP_DEEP_SLEEP, 32'h0}, 8);
        wt(2, 1000, n);
        chk("sleep delay", {31'h0, n > 700 && n < 800}, 32'h1);
        nope({`SFE_OP_WRITE_ENABLE, 32'h0}, 8, 1'b0);
        chk("latch in sleep", {30'h0, wen, slp}, 32'h1);
        u_host.send({`SFE_OP_WAKE_AND_ID, 32'h0}, 8);
        wt(0, 1000, n);
        chk("awake", {31'h0, slp}, 32'h0);
        summarize();
    end
endmodule

`default_nettype wire
